// ==== rcrb_config_bank.sv ====
// regulator configuration register bank reached by command code
`timescale 1ns/10ps
`include "rcrb_defines.svh"
module rcrb_config_bank
    import rcrb_pkg::*;
#(
    parameter int NPH      = 4,
    parameter int STEP_CYC = `RCRB_DELAY_STEP_CYC
) (
    input  wire logic           sys_clk,        // system clock, 10 MHz
    input  wire logic           rst,            // async reset, high
    input  wire logic [7:0]     cmd_code,       // command code of access
    input  wire logic           wr_stb,         // write strobe, one cycle
    input  wire logic [7:0]     wr_data,        // write data byte
    input  wire logic           rd_stb,         // read strobe, one cycle
    output logic      [7:0]     rd_data,        // read data byte
    output logic                rd_ack,         // read answered, one cycle
    output logic                rd_miss,        // read of unmapped code
    input  wire logic [7:0]     vid_pins,       // external voltage code pins
    input  wire logic [7:0]     vout_cmd_code,  // output voltage command value
    input  wire logic           ilim_active,    // core in current limit
    input  wire logic           latchoff_clear, // release latchoff
    output logic      [NPH-1:0] phase_en,       // per-phase enables
    output logic                vcode_src_sel,  // 1: command register source
    output logic      [7:0]     vcode,          // selected voltage code
    output logic                loop_test_en,   // loop test function on
    output logic                latchoff_en,    // latchoff timer enabled
    output logic      [2:0]     delay_code,     // soft-start delay code
    output logic      [3:0]     slew_tenths,    // slew rate in 0.1 V/ms
    output logic                latched_off     // latchoff has fired
);
    typedef struct packed {
        rcrb_cfg_t        cfg_pri;
        rcrb_cfg_t        cfg_dup;
        logic [2:0]       dly;
        logic [2:0]       slew;
        rcrb_rsp_t        rsp;
        logic [NPH-1:0]   phase_en;
        logic             vsrc;
        logic [7:0]       vcode;
        logic             loop_en;
        logic             lo_en;
        logic [2:0]       dly_o;
        logic [3:0]       slew_o;
        logic             latched;
    } rcrb_top_st_t;

    localparam rcrb_top_st_t ST_RST = '{
        cfg_pri:  rcrb_cfg_t'(`RCRB_CFG_RST),
        cfg_dup:  rcrb_cfg_t'(`RCRB_CFG_RST),
        dly:      `RCRB_SS_DELAY_RST,
        slew:     `RCRB_SS_SLEW_RST,
        rsp:      '0,
        phase_en: '0,
        vsrc:     1'b0,
        vcode:    8'h00,
        loop_en:  1'b0,
        lo_en:    1'b0,
        dly_o:    `RCRB_SS_DELAY_RST,
        slew_o:   4'h0,
        latched:  1'b0
    };

    rcrb_top_st_t   st_r;
    rcrb_top_st_t   st_nxt;
    rcrb_req_t      req;
    logic [NPH-1:0] ph_dec;
    logic           lo_fired;
    logic           lo_enable;

    assign req = '{cmd: cmd_code, wr_stb: wr_stb, wr_data: wr_data, rd_stb: rd_stb};

    assign lo_enable = st_r.cfg_pri.latchoff_en | st_r.cfg_dup.latchoff_en;

    rcrb_phase_decode #(
        .NPH       (NPH)
    ) u_phase (
        .phase_sel (st_r.cfg_pri.phase_sel),
        .phase_en  (ph_dec)
    );

    rcrb_latchoff_timer #(
        .STEP_CYC    (STEP_CYC)
    ) u_latch (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .enable      (lo_enable),
        .delay_code  (st_r.dly),
        .ilim_active (ilim_active),
        .clear       (latchoff_clear),
        .latched     (lo_fired)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.rd_ack  = 1'b0;
        st_nxt.rsp.rd_miss = 1'b0;
        st_nxt.rsp.rd_data = 8'h00;

        if (req.wr_stb) begin
            unique case (req.cmd)
                `RCRB_CMD_CFG_PRI: begin
                    st_nxt.cfg_pri = rcrb_cfg_t'(req.wr_data & `RCRB_CFG_WMASK);
                end
                `RCRB_CMD_CFG_DUP: begin
                    st_nxt.cfg_dup = rcrb_cfg_t'(req.wr_data & `RCRB_CFG_WMASK);
                end
                `RCRB_CMD_SS_DELAY: begin
                    st_nxt.dly = req.wr_data[2:0];
                end
                `RCRB_CMD_SS_SLEW: begin
                    st_nxt.slew = req.wr_data[2:0];
                end
                default: begin
                end
            endcase
        end

        if (req.rd_stb) begin
            st_nxt.rsp.rd_ack = 1'b1;
            unique case (req.cmd)
                `RCRB_CMD_CFG_PRI: begin
                    st_nxt.rsp.rd_data = st_r.cfg_pri;
                end
                `RCRB_CMD_CFG_DUP: begin
                    st_nxt.rsp.rd_data = st_r.cfg_dup;
                end
                `RCRB_CMD_SS_DELAY: begin
                    st_nxt.rsp.rd_data = {5'h00, st_r.dly};
                end
                `RCRB_CMD_SS_SLEW: begin
                    st_nxt.rsp.rd_data = {5'h00, st_r.slew};
                end
                default: begin
                    st_nxt.rsp.rd_miss = 1'b1;
                end
            endcase
        end

        st_nxt.phase_en = ph_dec;
        st_nxt.vsrc  = st_r.cfg_pri.vcode_src;
        st_nxt.vcode = st_r.cfg_pri.vcode_src ? vout_cmd_code : vid_pins;
        st_nxt.loop_en = st_r.cfg_pri.loop_test & st_r.cfg_dup.loop_test;
        st_nxt.lo_en = lo_enable;
        st_nxt.dly_o = st_r.dly;
        st_nxt.slew_o  = 4'(`RCRB_SLEW_BASE_TENTHS + `RCRB_SLEW_STEP_TENTHS * int'(st_r.slew));
        st_nxt.latched = lo_fired;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data       = st_r.rsp.rd_data;
    assign rd_ack        = st_r.rsp.rd_ack;
    assign rd_miss       = st_r.rsp.rd_miss;
    assign phase_en      = st_r.phase_en;
    assign vcode_src_sel = st_r.vsrc;
    assign vcode         = st_r.vcode;
    assign loop_test_en  = st_r.loop_en;
    assign latchoff_en   = st_r.lo_en;
    assign delay_code    = st_r.dly_o;
    assign slew_tenths   = st_r.slew_o;
    assign latched_off   = st_r.latched;
endmodule : rcrb_config_bank

// ==== rcrb_defines.svh ====
// command codes, field positions, reset values and timing counts of the config bank
`ifndef RCRB_DEFINES_SVH
`define RCRB_DEFINES_SVH

`define RCRB_CMD_CFG_PRI      8'hD2
`define RCRB_CMD_CFG_DUP      8'hD3
`define RCRB_CMD_SS_DELAY     8'hD4
`define RCRB_CMD_SS_SLEW      8'hD5

`define RCRB_CFG_RST          8'h52
`define RCRB_CFG_WMASK        8'h7E
`define RCRB_SS_DELAY_RST     3'h3
`define RCRB_SS_SLEW_RST      3'h2

`define RCRB_PHASE_MSB        6
`define RCRB_PHASE_LSB        4
`define RCRB_VSRC_BIT         3
`define RCRB_LOOP_BIT         2
`define RCRB_CLIM_BIT         1

`define RCRB_CLK_PERIOD_NS    100
`define RCRB_DELAY_STEP_NS    500000
`define RCRB_DELAY_STEP_CYC   ((`RCRB_DELAY_STEP_NS + `RCRB_CLK_PERIOD_NS - 1) / `RCRB_CLK_PERIOD_NS)
`define RCRB_LATCH_MULT       4
`define RCRB_SLEW_BASE_TENTHS 1
`define RCRB_SLEW_STEP_TENTHS 2

`endif

// ==== rcrb_pkg.sv ====
// types shared by the regulator configuration bank
package rcrb_pkg;

    typedef struct packed {
        logic       res7;
        logic [2:0] phase_sel;
        logic       vcode_src;
        logic       loop_test;
        logic       latchoff_en;
        logic       res0;
    } rcrb_cfg_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic       wr_stb;
        logic [7:0] wr_data;
        logic       rd_stb;
    } rcrb_req_t;

    typedef struct packed {
        logic [7:0] rd_data;
        logic       rd_ack;
        logic       rd_miss;
    } rcrb_rsp_t;

    typedef struct packed {
        logic [3:0] phase_en;
        logic       vcode_src_sel;
        logic       loop_test_en;
        logic       latchoff_en;
        logic [2:0] delay_code;
        logic [3:0] slew_tenths;
    } rcrb_core_t;

endpackage : rcrb_pkg

// ==== rcrb_phase_decode.sv ====
// active phase count decode into per-phase enables
`timescale 1ns/10ps
module rcrb_phase_decode
    import rcrb_pkg::*;
#(
    parameter int NPH = 4
) (
    input  wire logic [2:0]     phase_sel,   // phase field code
    output logic      [NPH-1:0] phase_en     // per-phase enable
);
    logic [2:0] count;

    // codes 000/100/010/110 give 1..4; bit 4 of the field is ignored
    assign count = {1'b0, phase_sel[1], phase_sel[2]} + 3'h1;

    genvar i;
    generate
        for (i = 0; i < NPH; i++) begin : g_ph
            assign phase_en[i] = (count > 3'(i));
        end
    endgenerate
endmodule : rcrb_phase_decode

// ==== rcrb_latchoff_timer.sv ====
// current limit latchoff timer, four times the soft-start delay
`timescale 1ns/10ps
`include "rcrb_defines.svh"
module rcrb_latchoff_timer
    import rcrb_pkg::*;
#(
    parameter int STEP_CYC = `RCRB_DELAY_STEP_CYC
) (
    input  wire logic       sys_clk,       // system clock
    input  wire logic       rst,           // async reset, high
    input  wire logic       enable,        // latchoff allowed
    input  wire logic [2:0] delay_code,    // soft-start delay code
    input  wire logic       ilim_active,   // core is in current limit
    input  wire logic       clear,         // release latched off state
    output logic            latched        // latchoff has fired
);
    localparam int LIM_MAX = STEP_CYC * `RCRB_LATCH_MULT * 8;
    localparam int CW      = $clog2(LIM_MAX + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          latched;
    } rcrb_lt_st_t;

    rcrb_lt_st_t st_r;
    rcrb_lt_st_t st_nxt;
    logic [CW-1:0] limit;

    assign limit = CW'((int'(delay_code) + 1) * STEP_CYC * `RCRB_LATCH_MULT);

    always_comb begin
        st_nxt = st_r;
        if (!ilim_active || !enable) begin
            st_nxt.cnt = '0;
        end else if (!st_r.latched) begin
            if (st_r.cnt + CW'(1) >= limit) begin
                st_nxt.latched = 1'b1;
                st_nxt.cnt     = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end
        // a firing in the clear cycle still latches
        if (clear && !(st_nxt.latched && !st_r.latched)) begin
            st_nxt.latched = 1'b0;
            st_nxt.cnt     = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign latched = st_r.latched;
endmodule : rcrb_latchoff_timer

// ==== rcrb_core_model.sv ====
// far side model: core current limit and voltage code sources
`timescale 1ns/10ps
module rcrb_core_model (
    input  wire logic       limit_req,     // bench asks for limit
    output logic      [7:0] vid_pins,      // pin voltage code
    output logic      [7:0] vout_cmd_code, // command voltage code
    output logic            ilim_active    // core in current limit
);
    assign vid_pins      = 8'h3C;
    assign vout_cmd_code = 8'hA5;
    assign ilim_active   = limit_req;
endmodule : rcrb_core_model

// ==== rcrb_config_bank_props.sv ====
// assertions on the config bank ports
`timescale 1ns/10ps
module rcrb_config_bank_props #(
    parameter int NPH = 4
) (
    input wire logic           sys_clk,       // clock
    input wire logic           rst,           // reset
    input wire logic [7:0]     cmd_code,      // code
    input wire logic           wr_stb,        // write
    input wire logic [7:0]     wr_data,       // wdata
    input wire logic           rd_stb,        // read
    input wire logic [7:0]     rd_data,       // rdata
    input wire logic           rd_ack,        // ack
    input wire logic           rd_miss,       // miss
    input wire logic [7:0]     vid_pins,      // pins
    input wire logic [7:0]     vout_cmd_code, // cmd value
    input wire logic [NPH-1:0] phase_en,      // phases
    input wire logic           vcode_src_sel, // source
    input wire logic [7:0]     vcode,         // code out
    input wire logic           loop_test_en,  // loop
    input wire logic           latchoff_en    // latchoff
);
    logic [7:0] pri_r;
    logic [7:0] dup_r;
    // shadow of both config registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pri_r <= 8'h52;
            dup_r <= 8'h52;
        end else if (wr_stb) begin
            if (cmd_code == 8'hD2) pri_r <= wr_data & 8'h7E;
            if (cmd_code == 8'hD3) dup_r <= wr_data & 8'h7E;
        end
    end
    function automatic logic [3:0] ph(input logic [2:0] c);
        return {c[1] & c[2], c[1], c[1] | c[2], 1'b1};
    endfunction : ph
    logic [3:0] ph_exp;
    logic [7:0] vc_exp;
    logic       loop_exp;
    logic       clim_exp;
    // expected core outputs from the shadows
    assign ph_exp   = ph(pri_r[6:4]);
    assign vc_exp   = pri_r[3] ? vout_cmd_code : vid_pins;
    assign loop_exp = pri_r[2] & dup_r[2];
    assign clim_exp = pri_r[1] | dup_r[1];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_ack; rd_stb |=> rd_ack; endproperty
    a_ack: assert property (p_ack) else $error("no read ack");
    property p_miss; rd_stb && !(cmd_code inside {[8'hD2:8'hD5]}) |=> rd_miss && rd_data == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped read wrong");
    property p_rdpri; rd_stb && cmd_code == 8'hD2 |=> rd_data == $past(pri_r); endproperty
    a_rdpri: assert property (p_rdpri) else $error("config read wrong");
    property p_phase; !$past(rst) |-> phase_en == $past(ph_exp); endproperty
    a_phase: assert property (p_phase) else $error("phase enables wrong");
    property p_vsrc; !$past(rst) |-> vcode_src_sel == $past(pri_r[3]); endproperty
    a_vsrc: assert property (p_vsrc) else $error("source select wrong");
    property p_vcode; !$past(rst) |-> vcode == $past(vc_exp); endproperty
    a_vcode: assert property (p_vcode) else $error("voltage code wrong");
    property p_loop; !$past(rst) |-> loop_test_en == $past(loop_exp); endproperty
    a_loop: assert property (p_loop) else $error("loop test wrong");
    property p_clim; !$past(rst) |-> latchoff_en == $past(clim_exp); endproperty
    a_clim: assert property (p_clim) else $error("latchoff enable wrong");
endmodule : rcrb_config_bank_props
bind rcrb_config_bank rcrb_config_bank_props #(.NPH(NPH)) i_props (.sys_clk, .rst, .cmd_code, .wr_stb,
    .wr_data, .rd_stb, .rd_data, .rd_ack, .rd_miss, .vid_pins, .vout_cmd_code, .phase_en,
    .vcode_src_sel, .vcode, .loop_test_en, .latchoff_en);

// ==== rcrb_config_bank_tb.sv ====
// self-checking bench for the config bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rcrb_config_bank_tb;
    logic       sys_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, limit_req = 0, latchoff_clear = 0;
    logic [7:0] cmd_code = 0, wr_data = 0, rd_data, vid_pins, vout_cmd_code, vcode;
    logic       rd_ack, rd_miss, ilim_active, vcode_src_sel, loop_test_en, latchoff_en, latched_off;
    logic [3:0] phase_en, slew_tenths;
    logic [2:0] delay_code;
    int         checked = 0, n_mismatch = 0, cyc_cnt = 0;
    logic [2:0] ph_code [4] = '{3'b000, 3'b100, 3'b010, 3'b110};
    logic [3:0] ph_exp [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
    always #50 sys_clk = ~sys_clk;
    rcrb_core_model i_core (.limit_req(limit_req), .vid_pins(vid_pins), .vout_cmd_code(vout_cmd_code),
        .ilim_active(ilim_active));
    rcrb_config_bank #(.STEP_CYC(2)) i_dut (.sys_clk(sys_clk), .rst(rst), .cmd_code(cmd_code),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_ack(rd_ack),
        .rd_miss(rd_miss), .vid_pins(vid_pins), .vout_cmd_code(vout_cmd_code), .ilim_active(ilim_active),
        .latchoff_clear(latchoff_clear), .phase_en(phase_en), .vcode_src_sel(vcode_src_sel), .vcode(vcode),
        .loop_test_en(loop_test_en), .latchoff_en(latchoff_en), .delay_code(delay_code),
        .slew_tenths(slew_tenths), .latched_off(latched_off));
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // write, then wait until core outputs follow
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        wr_data = d;
        wr_stb = 1;
        @(negedge sys_clk);
        wr_stb = 0;
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        @(negedge sys_clk);
        cmd_code = c;
        rd_stb = 1;
        @(negedge sys_clk);
        rd_stb = 0;
        `CHK("rd_ack", 1'b1, rd_ack)
        `CHK("rd_data", e, rd_data)
    endtask : rd
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 0;
        rd(8'hD2, 8'h52);
        rd(8'hD3, 8'h52);
        rd(8'hD4, 8'h03);
        rd(8'hD5, 8'h02);
        `CHK("phase_en", 4'h3, phase_en)
        `CHK("slew_tenths", 4'd5, slew_tenths)
        rd(8'hD6, 8'h00);
        `CHK("rd_miss", 1'b1, rd_miss)
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'hD2, {1'b0, ph_code[i], 4'h0});
            `CHK("phase_en", ph_exp[i], phase_en)
        end
        wr(8'hD2, 8'hFF);
        rd(8'hD2, 8'h7E);
        `CHK("vcode", 8'hA5, vcode)
        `CHK("loop_test_en", 1'b0, loop_test_en)
        wr(8'hD3, 8'h04);
        `CHK("loop_test_en", 1'b1, loop_test_en)
        `CHK("latchoff_en", 1'b1, latchoff_en)
        wr(8'hD2, 8'h00);
        `CHK("vcode", 8'h3C, vcode)
        `CHK("loop_test_en", 1'b0, loop_test_en)
        `CHK("latchoff_en", 1'b0, latchoff_en)
        wr(8'hD3, 8'h02);
        `CHK("latchoff_en", 1'b1, latchoff_en)
        $display("config test done");
        for (int i = 0; i < 8; i++) begin
            wr(8'hD5, 8'(i));
            `CHK("slew_tenths", 4'(1 + 2 * i), slew_tenths)
            wr(8'hD4, 8'(8'hF8 | i));
            rd(8'hD4, 8'(i));
            `CHK("delay_code", 3'(i), delay_code)
        end
        $display("soft-start test done");
        wr(8'hD4, 8'h01);
        limit_req = 1;
        repeat (16) @(negedge sys_clk);
        `CHK("latched_off", 1'b0, latched_off)
        repeat (1) @(negedge sys_clk);
        `CHK("latched_off", 1'b1, latched_off)
        limit_req = 0;
        latchoff_clear = 1;
        @(negedge sys_clk);
        latchoff_clear = 0;
        wr(8'hD3, 8'h00);
        limit_req = 1;
        repeat (40) @(negedge sys_clk);
        `CHK("latched_off", 1'b0, latched_off)
        limit_req = 0;
        $display("latchoff test done");
        summarize();
    end
endmodule : rcrb_config_bank_tb
